// File: logic/efp_host.sv
`timescale 1ns/1ps
`include "efp_params.svh"
module efp_host
  import efp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user request
  input wire logic req,
  input wire logic req_write,
  input wire logic [`EFP_AW-1:0] req_addr,
  input wire logic [`EFP_DW-1:0] req_data,
  input wire logic ctrl_released,
  output logic busy,
  output logic done,
  output logic [`EFP_DW-1:0] rd_data,
  output logic flash_ready,
  // pins
  efp_if.host bus
);
  typedef struct packed {
    efp_hstate_t st_q;
    logic wr_q;
    logic [`EFP_AW-1:0] addr_q;
    logic [`EFP_DW-1:0] data_q;
    logic drive_q;
    logic sel_n_q;
    logic oe_n_q;
    logic we_n_q;
    logic done_q;
    logic [`EFP_DW-1:0] rd_q;
    logic rdy_q;
    logic busy_q;
    logic cfg_n_q;
  } efp_ho_t;
  efp_ho_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done_q = 1'b0;
    s_d.rdy_q = bus.flash_ready_busy;
    case (s_q.st_q)
      EFP_H_IDLE: begin
        if (req && ctrl_released) begin
          s_d.wr_q = req_write;
          s_d.addr_q = req_addr;
          s_d.data_q = req_data;
          s_d.sel_n_q = 1'b0;
          s_d.drive_q = req_write;
          s_d.st_q = req_write ? EFP_H_SETUP : EFP_H_RD_TURN;
        end
      end
      EFP_H_SETUP: begin
        s_d.we_n_q = 1'b0;
        s_d.st_q = EFP_H_STROBE;
      end
      EFP_H_STROBE: begin
        s_d.we_n_q = 1'b1;
        s_d.st_q = EFP_H_DONE;
      end
      EFP_H_RD_TURN: begin
        s_d.oe_n_q = 1'b0;
        s_d.st_q = EFP_H_RD_WAIT;
      end
      EFP_H_RD_WAIT: begin
        // flash drivers only turn on at this edge; bus still floats, so nothing to take yet
        s_d.st_q = EFP_H_DONE;
        s_d.oe_n_q = 1'b0;
      end
      EFP_H_DONE: begin
        if (!s_q.wr_q) begin
          s_d.rd_q = bus.dq;
        end
        s_d.drive_q = 1'b0;
        s_d.oe_n_q = 1'b1;
        s_d.sel_n_q = 1'b1;
        s_d.done_q = 1'b1;
        s_d.st_q = EFP_H_IDLE;
      end
      default: s_d.st_q = EFP_H_IDLE;
    endcase
    s_d.busy_q = s_d.st_q != EFP_H_IDLE;
    // hold the controller off while we own the bus
    s_d.cfg_n_q = ~s_d.drive_q & s_d.sel_n_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st_q: EFP_H_IDLE, wr_q: 1'b0, addr_q: '0, data_q: '0, drive_q: 1'b0, sel_n_q: 1'b1,
        oe_n_q: 1'b1, we_n_q: 1'b1, done_q: 1'b0, rd_q: '0, rdy_q: 1'b1, busy_q: 1'b0, cfg_n_q: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.addr = s_q.addr_q;
  assign bus.dq_host_o = s_q.data_q;
  assign bus.dq_host_oe = s_q.drive_q;
  assign bus.select_n = s_q.sel_n_q;
  assign bus.out_en_n = s_q.oe_n_q;
  assign bus.wr_n = s_q.we_n_q;
  assign bus.flash_reset_n = 1'b1;
  assign bus.write_protect_n = 1'b1;
  assign bus.word_mode = 1'b1;
  assign bus.config_start_n = s_q.cfg_n_q;
  assign busy = s_q.busy_q;
  assign done = s_q.done_q;
  assign rd_data = s_q.rd_q;
  assign flash_ready = s_q.rdy_q;
endmodule // efp_host

// File: logic/efp_params.svh
`ifndef EFP_PARAMS_SVH
`define EFP_PARAMS_SVH
`define EFP_AW 21
`define EFP_DW 16
`define EFP_DEPTH 64
`define EFP_IDX_W 6
`define EFP_ERASED 16'hFFFF
`define EFP_BUSY_NS 50
`define EFP_CLK_NS 10
`define EFP_BUSY_CYC ((`EFP_BUSY_NS + `EFP_CLK_NS - 1) / `EFP_CLK_NS)
`define EFP_CNT_W 8
`define EFP_CMD_ERASE 16'h0020
`define EFP_CMD_PROG 16'h0040
`define EFP_CMD_READ 16'h00FF
`endif

// File: logic/efp_pkg.sv
`include "efp_params.svh"
package efp_pkg;
  typedef enum logic [1:0] {EFP_IDLE, EFP_PROG_ARMED, EFP_BUSY} efp_fstate_t;
  typedef enum logic [2:0] {EFP_H_IDLE, EFP_H_SETUP, EFP_H_STROBE, EFP_H_RD_TURN, EFP_H_RD_WAIT,
    EFP_H_DONE} efp_hstate_t;
endpackage

// File: logic/efp_if.sv
`timescale 1ns/1ps
`include "efp_params.svh"
interface efp_if;
  logic [`EFP_AW-1:0] addr;
  logic [`EFP_DW-1:0] dq_host_o;
  logic dq_host_oe;
  logic [`EFP_DW-1:0] dq_flash_o;
  logic dq_flash_oe;
  logic [`EFP_DW-1:0] dq;
  logic select_n;
  logic out_en_n;
  logic wr_n;
  logic flash_reset_n;
  logic write_protect_n;
  logic word_mode;
  logic flash_ready_busy;
  logic config_start_n;
  assign dq = dq_flash_oe ? dq_flash_o : (dq_host_oe ? dq_host_o : `EFP_ERASED);
  modport flash (input addr, dq, select_n, out_en_n, wr_n, flash_reset_n, write_protect_n, word_mode,
    output dq_flash_o, dq_flash_oe, flash_ready_busy);
  modport host (input dq, flash_ready_busy, output addr, dq_host_o, dq_host_oe, select_n, out_en_n, wr_n,
    flash_reset_n, write_protect_n, word_mode, config_start_n);
endinterface

// File: logic/efp_flash.sv
`timescale 1ns/1ps
`include "efp_params.svh"
module efp_flash
  import efp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  efp_if.flash bus,
  // status
  output logic standby
);
  typedef struct packed {
    logic wr_n_q;
    logic [`EFP_AW-1:0] addr_q;
    logic [`EFP_DW-1:0] data_q;
    efp_fstate_t st_q;
    logic [`EFP_CNT_W-1:0] cnt_q;
    logic ready_q;
    logic oe_q;
    logic [`EFP_DW-1:0] rd_q;
    logic standby_q;
  } efp_fl_t;
  efp_fl_t s_q, s_d;
  logic [`EFP_DW-1:0] mem [`EFP_DEPTH];
  logic wr_rise;
  logic do_prog;
  logic do_erase;

  function automatic logic [`EFP_IDX_W-1:0] idx(input logic [`EFP_AW-1:0] a);
    idx = a[`EFP_IDX_W-1:0];
  endfunction

  // strobe edge detected in clk domain; strobe pins are synchronous here
  assign wr_rise = s_q.wr_n_q == 1'b0 && bus.wr_n == 1'b1 && bus.select_n == 1'b0
    && bus.flash_reset_n == 1'b1;
  assign do_prog = wr_rise && s_q.st_q == EFP_PROG_ARMED;
  assign do_erase = wr_rise && s_q.st_q == EFP_IDLE && bus.dq == `EFP_CMD_ERASE;

  always_comb begin
    s_d = s_q;
    s_d.wr_n_q = bus.wr_n;
    s_d.standby_q = bus.select_n;
    if (wr_rise) begin
      s_d.addr_q = bus.addr;
      s_d.data_q = bus.dq;
    end
    case (s_q.st_q)
      EFP_IDLE: begin
        if (wr_rise && bus.dq == `EFP_CMD_PROG) begin
          s_d.st_q = EFP_PROG_ARMED;
        end else if (do_erase) begin
          s_d.st_q = EFP_BUSY;
          s_d.cnt_q = `EFP_CNT_W'(`EFP_BUSY_CYC);
          s_d.ready_q = 1'b0;
        end
      end
      EFP_PROG_ARMED: begin
        if (wr_rise) begin
          s_d.st_q = EFP_BUSY;
          s_d.cnt_q = `EFP_CNT_W'(`EFP_BUSY_CYC);
          s_d.ready_q = 1'b0;
        end
      end
      EFP_BUSY: begin
        if (s_q.cnt_q <= `EFP_CNT_W'(1)) begin
          s_d.st_q = EFP_IDLE;
          s_d.ready_q = 1'b1;
        end else begin
          s_d.cnt_q = s_q.cnt_q - `EFP_CNT_W'(1);
        end
      end
      default: s_d.st_q = EFP_IDLE;
    endcase
    // read path: drive only while selected, enabled and not writing
    s_d.oe_q = !bus.select_n && !bus.out_en_n && bus.wr_n && bus.flash_reset_n;
    s_d.rd_q = mem[idx(bus.addr)];
    if (!bus.flash_reset_n) begin
      s_d.st_q = EFP_IDLE;
      s_d.ready_q = 1'b1;
      s_d.oe_q = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{wr_n_q: 1'b1, addr_q: '0, data_q: '0, st_q: EFP_IDLE, cnt_q: '0, ready_q: 1'b1, oe_q: 1'b0,
        rd_q: '0, standby_q: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // small model array; only low address bits decoded
  always_ff @(posedge clk) begin
    if (do_prog) begin
      mem[idx(bus.addr)] <= mem[idx(bus.addr)] & bus.dq;
    end else if (do_erase) begin
      for (int i = 0; i < `EFP_DEPTH; i++) begin
        mem[i] <= `EFP_ERASED;
      end
    end
  end

  assign bus.dq_flash_o = s_q.rd_q;
  assign bus.dq_flash_oe = s_q.oe_q;
  assign bus.flash_ready_busy = s_q.ready_q;
  assign standby = s_q.standby_q;
endmodule // efp_flash

// File: bench/efp_chk.sv
`timescale 1ns/1ps
module efp_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus pins
  input wire logic select_n,
  input wire logic out_en_n,
  input wire logic wr_n,
  input wire logic flash_reset_n,
  input wire logic dq_host_oe,
  input wire logic dq_flash_oe,
  input wire logic write_protect_n,
  input wire logic word_mode,
  input wire logic flash_ready_busy,
  input wire logic config_start_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // drivers follow the pins one cycle late
  a_flash_gate:
    assert property (dq_flash_oe == $past(!select_n && !out_en_n && wr_n && flash_reset_n)) else $error("flash drive");
  a_strobe_pulse:
    assert property ($fell(wr_n) |=> wr_n) else $error("strobe width");
  a_write_driven:
    assert property (!wr_n |-> !select_n && dq_host_oe && out_en_n) else $error("write not driven");
  a_read_release:
    assert property (!out_en_n |-> !dq_host_oe && wr_n) else $error("host drives in read");
  a_no_contention:
    assert property (!(dq_flash_oe && dq_host_oe)) else $error("bus contention");
  a_busy_bound:
    assert property ($fell(flash_ready_busy) |-> ##[1:8] flash_ready_busy) else $error("busy too long");
  a_cfg_held:
    assert property (!select_n |-> !config_start_n) else $error("controller not held");
  a_pin_ties:
    assert property (write_protect_n && word_mode) else $error("pin tie low");
endmodule // efp_chk

// File: bench/tb.sv
`timescale 1ns/1ps
`include "efp_params.svh"
module tb;
  import efp_pkg::*;
  logic clk, rst, req, req_write, ctrl_released, busy, done, flash_ready, standby;
  logic [`EFP_AW-1:0] req_addr, a;
  logic [`EFP_DW-1:0] req_data, rd_data, d;
  logic [`EFP_DW-1:0] mem [`EFP_DEPTH];
  int err_count, compares, seed, i, n;
  efp_if bus ();
  efp_flash efp_flash_inst (.clk(clk), .rst(rst), .bus(bus), .standby(standby));
  efp_host efp_host_inst (.clk(clk), .rst(rst), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_data(req_data), .ctrl_released(ctrl_released), .busy(busy), .done(done), .rd_data(rd_data),
    .flash_ready(flash_ready), .bus(bus));
  efp_chk efp_chk_inst (.clk(clk), .rst(rst), .select_n(bus.select_n), .out_en_n(bus.out_en_n),
    .wr_n(bus.wr_n), .flash_reset_n(bus.flash_reset_n), .dq_host_oe(bus.dq_host_oe),
    .dq_flash_oe(bus.dq_flash_oe), .write_protect_n(bus.write_protect_n), .word_mode(bus.word_mode),
    .flash_ready_busy(bus.flash_ready_busy), .config_start_n(bus.config_start_n));
  // programming only clears bits
  function automatic logic [`EFP_DW-1:0] prog(input logic [`EFP_DW-1:0] o, input logic [`EFP_DW-1:0] v);
    return o & v;
  endfunction
  task automatic chk(input logic [`EFP_DW-1:0] got, input logic [`EFP_DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic op(input logic wr, input logic [`EFP_AW-1:0] ad, input logic [`EFP_DW-1:0] dt);
    @(posedge clk);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= ad;
    req_data <= dt;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(16'(done), 16'h0001);
    chk(16'(standby), 16'h0000);
    // ready copy lags the write by two cycles
    repeat (2) @(negedge clk);
    while (flash_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(16'(flash_ready), 16'h0001);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    seed = 29626;
    rst = 1'b1;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_data = '0;
    ctrl_released = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(16'(standby), 16'h0001);
    op(1'b1, '0, `EFP_CMD_ERASE);
    for (i = 0; i < `EFP_DEPTH; i++) mem[i] = `EFP_ERASED;
    for (i = 0; i < 16; i++) begin
      a = (i == 0) ? 21'h1FFFFF : 21'($random(seed));
      d = (i == 1) ? 16'h0000 : 16'($random(seed));
      op(1'b1, a, `EFP_CMD_PROG);
      op(1'b1, a, d);
      mem[a[5:0]] = prog(mem[a[5:0]], d);
      op(1'b0, a, 16'h0000);
      chk(rd_data, mem[a[5:0]]);
    end
    op(1'b1, a, `EFP_CMD_ERASE);
    op(1'b0, a, 16'h0000);
    chk(rd_data, `EFP_ERASED);
    chk(16'(standby), 16'h0001);
    @(posedge clk);
    ctrl_released <= 1'b0;
    req <= 1'b1;
    req_write <= 1'b1;
    req_data <= `EFP_CMD_PROG;
    @(posedge clk);
    req <= 1'b0;
    repeat (8) @(negedge clk);
    chk(16'(busy), 16'h0000);
    @(posedge clk);
    ctrl_released <= 1'b1;
    op(1'b0, a, 16'h0000);
    chk(rd_data, `EFP_ERASED);
    results();
  end
endmodule // tb
